// ==== src/urx_pkg.sv ====
// Constants and types for the serial port receive, transmit and control block
package urx_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_POWER_CONTROL  = 8'h80;
  localparam logic [7:0] OFS_HOLDING        = 8'h84;
  localparam logic [7:0] OFS_SLAVE_ADDRESS  = 8'h88;
  localparam logic [7:0] OFS_SLAVE_MASK     = 8'h8C;
  localparam logic [7:0] OFS_BAUD_DIVIDER   = 8'h90;
  localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h98;

  // Serial control field positions
  localparam int unsigned BIT_UPPER_MODE = 7;
  localparam int unsigned BIT_LOWER_MODE = 6;
  localparam int unsigned BIT_MULTIPROC  = 5;
  localparam int unsigned BIT_RX_ENABLE  = 4;
  localparam int unsigned BIT_TX_NINTH   = 3;
  localparam int unsigned BIT_RX_NINTH   = 2;
  localparam int unsigned BIT_TX_DONE    = 1;
  localparam int unsigned BIT_RX_DONE    = 0;
  // Power control field positions
  localparam int unsigned BIT_DOUBLE_RATE    = 7;
  localparam int unsigned BIT_FRAMING_SELECT = 6;

  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_BAUD_DIV = 8'h00;

  // ----------------------------------------------------------------------
  // Modes and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT  = 2'h0;
  localparam logic [1:0] MODE_8VAR   = 2'h1;
  localparam logic [1:0] MODE_9FIX   = 2'h2;
  localparam logic [1:0] MODE_9VAR   = 2'h3;
  // Mode 0 bit period end count (counter runs 0 to 5, 6 core clocks); clock phase split point
  localparam logic [2:0] M0_LAST     = 3'h5;
  localparam logic [2:0] M0_HALF     = 3'h3;
  // Oversample tick reload for the fixed 9-bit rate: /32 or /16
  localparam logic [7:0] FIX_RELOAD_SLOW = 8'h01;
  localparam logic [7:0] FIX_RELOAD_FAST = 8'h00;
  localparam logic [3:0] SAMPLE_A    = 4'h7;
  localparam logic [3:0] SAMPLE_B    = 4'h8;
  localparam logic [3:0] SAMPLE_C    = 4'h9;
  localparam logic [3:0] LAST_PHASE  = 4'hF;
  // Index of the stop bit among bits after the start bit
  localparam logic [3:0] STOP_IDX_8  = 4'h8;
  localparam logic [3:0] STOP_IDX_9  = 4'h9;
  localparam logic [3:0] M0_BITS     = 4'h8;
  localparam logic [3:0] TX_BITS_8   = 4'hA;
  localparam logic [3:0] TX_BITS_9   = 4'hB;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_SHIFT = 2'b10
  } urx_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SHIFT = 2'b11
  } urx_tx_state_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [7:0] writedata;
  } urx_avs_req_t;

  typedef struct packed {
    logic [7:0] readdata;
    logic       waitrequest;
  } urx_avs_rsp_t;

endpackage : urx_pkg

// ==== src/urx_uart.sv ====
// Serial port with multiprocessor address filtering and Avalon-MM registers
module urx_uart (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire urx_pkg::urx_avs_req_t avsReq,
  output urx_pkg::urx_avs_rsp_t      avsRsp,
  input  wire logic                  rxd,
  output logic                       txd,
  output logic                       shiftClk
);
  import urx_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          waitreq;
    logic [7:0]    readdata;
    logic          sm0;
    logic          sm1;
    logic          sm2;
    logic          ren;
    logic          tb8;
    logic          rb8;
    logic          ti;
    logic          ri;
    logic          fe;
    logic          smod1;
    logic          framing_select;
    logic [7:0]    rxBuf;
    logic [7:0]    slave_address_register;
    logic [7:0]    slave_address_mask;
    logic [7:0]    baudDiv;
    logic [7:0]    tickCnt;
    logic [2:0]    m0Cnt;
    logic          rxS1;
    logic          rxS2;
    logic          rxLast;
    urx_rx_state_t rxState;
    logic [3:0]    rxCnt;
    logic [3:0]    rxBit;
    logic          samp7;
    logic          samp8;
    logic [8:0]    rxShift;
    urx_tx_state_t txState;
    logic [3:0]    txCnt;
    logic [3:0]    txBits;
    logic [10:0]   txShift;
    logic          txd;
    logic          shiftClk;
  } urx_state_t;

  urx_state_t st;
  urx_state_t next_st;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Match where mask bits that are zero are ignored
  function automatic logic addrHit(input logic [7:0] rx,
                                   input logic [7:0] want,
                                   input logic [7:0] care);
    addrHit = (((rx ^ want) & care) == 8'h00);
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [1:0] mode;
  logic       nineBit;
  logic       tick;
  logic       busWr;
  logic       vote;
  logic       rxFinal;
  logic       rxAccept;
  logic       addrMatch;
  logic [7:0] rxData;
  logic       rxNinth;
  logic       startBad;
  logic       rxFall;

  assign mode    = {st.sm0, st.sm1};
  assign nineBit = mode[1];
  assign tick    = (st.tickCnt == 8'h00);
  // Request is served at the edge where waitrequest is already low
  assign busWr   = avsReq.write && !st.waitreq;
  assign vote    = maj3(st.samp7, st.samp8, st.rxS2);
  assign rxFall  = st.rxLast && !st.rxS2;
  assign startBad = (st.rxState == RX_START) && tick
                    && (st.rxCnt == SAMPLE_C) && vote;
  assign rxFinal = (st.rxState == RX_DATA) && tick && (st.rxCnt == SAMPLE_C)
                   && (st.rxBit == (nineBit ? STOP_IDX_9 : STOP_IDX_8));
  assign rxData  = nineBit ? st.rxShift[7:0] : st.rxShift[8:1];
  assign rxNinth = nineBit ? st.rxShift[8] : vote;
  assign addrMatch = addrHit(rxData, st.slave_address_register & st.slave_address_mask, st.slave_address_mask)
                   || addrHit(rxData, 8'hFF, st.slave_address_register | st.slave_address_mask);
  // Filter: 8-bit needs stop high, 9-bit needs address flag and a match
  assign rxAccept = !st.ri && (!st.sm2 ||
                    (nineBit ? (rxNinth && addrMatch) : vote));

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rxS1 = rxd;
    next_st.rxS2 = st.rxS1;

    // Bus slave: one wait state, unmapped reads return zero
    next_st.waitreq = !((avsReq.read || avsReq.write) && st.waitreq);
    if (avsReq.read && st.waitreq) begin
      case (avsReq.address)
        OFS_SERIAL_CONTROL: next_st.readdata = {st.framing_select ? st.fe : st.sm0,
                              st.sm1, st.sm2, st.ren, st.tb8, st.rb8,
                              st.ti, st.ri};
        OFS_POWER_CONTROL:  next_st.readdata = {st.smod1, st.framing_select, 6'h00};
        OFS_HOLDING:        next_st.readdata = st.rxBuf;
        OFS_SLAVE_ADDRESS:  next_st.readdata = st.slave_address_register;
        OFS_SLAVE_MASK:     next_st.readdata = st.slave_address_mask;
        OFS_BAUD_DIVIDER:   next_st.readdata = st.baudDiv;
        default:            next_st.readdata = 8'h00;
      endcase
    end
    if (busWr) begin
      case (avsReq.address)
        OFS_SERIAL_CONTROL: begin
          if (st.framing_select) begin
            next_st.fe = avsReq.writedata[BIT_UPPER_MODE];
          end else begin
            next_st.sm0 = avsReq.writedata[BIT_UPPER_MODE];
          end
          next_st.sm1 = avsReq.writedata[BIT_LOWER_MODE];
          next_st.sm2 = avsReq.writedata[BIT_MULTIPROC];
          next_st.ren = avsReq.writedata[BIT_RX_ENABLE];
          next_st.tb8 = avsReq.writedata[BIT_TX_NINTH];
          next_st.rb8 = avsReq.writedata[BIT_RX_NINTH];
          next_st.ti  = avsReq.writedata[BIT_TX_DONE];
          next_st.ri  = avsReq.writedata[BIT_RX_DONE];
        end
        OFS_POWER_CONTROL: begin
          next_st.smod1 = avsReq.writedata[BIT_DOUBLE_RATE];
          next_st.framing_select = avsReq.writedata[BIT_FRAMING_SELECT];
        end
        OFS_SLAVE_ADDRESS: next_st.slave_address_register   = avsReq.writedata;
        OFS_SLAVE_MASK:    next_st.slave_address_mask   = avsReq.writedata;
        OFS_BAUD_DIVIDER:  next_st.baudDiv = avsReq.writedata;
        default: ;
      endcase
    end

    // Oversample tick at sixteen times the bit rate
    if (tick) begin
      case (mode)
        MODE_9FIX: next_st.tickCnt = st.smod1 ? FIX_RELOAD_FAST
                                              : FIX_RELOAD_SLOW;
        default:   next_st.tickCnt = st.baudDiv;
      endcase
    end else begin
      next_st.tickCnt = st.tickCnt - 8'h01;
    end
    next_st.m0Cnt = (st.m0Cnt == M0_LAST) ? 3'h0 : st.m0Cnt + 3'h1;

    // Receiver
    next_st.rxLast = tick ? st.rxS2 : st.rxLast;
    case (st.rxState)
      RX_IDLE: begin
        if (st.ren && mode == MODE_SHIFT && !st.ri
            && st.txState == TX_IDLE && st.m0Cnt == M0_LAST) begin
          next_st.rxState = RX_SHIFT;
          next_st.rxBit   = 4'h0;
        end else if (st.ren && mode != MODE_SHIFT && tick && rxFall) begin
          next_st.rxState = RX_START;
          next_st.rxCnt   = 4'h0;
        end
      end
      RX_START, RX_DATA: begin
        if (tick) begin
          next_st.rxCnt = st.rxCnt + 4'h1;
          if (st.rxCnt == SAMPLE_A) begin
            next_st.samp7 = st.rxS2;
          end
          if (st.rxCnt == SAMPLE_B) begin
            next_st.samp8 = st.rxS2;
          end
          if (st.rxCnt == SAMPLE_C) begin
            if (st.rxState == RX_START) begin
              next_st.rxState = vote ? RX_IDLE : RX_DATA;
              next_st.rxBit   = 4'h0;
            end else if (rxFinal) begin
              next_st.rxState = RX_IDLE;
              if (!vote) begin
                next_st.fe = 1'b1;
              end
              if (rxAccept) begin
                next_st.rxBuf = rxData;
                next_st.rb8   = rxNinth;
                next_st.ri    = 1'b1;
              end
            end else begin
              next_st.rxShift = {vote, st.rxShift[8:1]};
              next_st.rxBit   = st.rxBit + 4'h1;
            end
          end
        end
      end
      RX_SHIFT: begin
        if (st.m0Cnt == M0_LAST) begin
          next_st.rxShift = {st.rxS2, st.rxShift[8:1]};
          next_st.rxBit   = st.rxBit + 4'h1;
          if (st.rxBit == M0_BITS - 4'h1) begin
            next_st.rxState = RX_IDLE;
            next_st.rxBuf   = {st.rxS2, st.rxShift[8:2]};
            next_st.ri      = 1'b1;
          end
        end
      end
      default: next_st.rxState = RX_IDLE;
    endcase

    // Transmitter: a write to the holding register starts a frame
    case (st.txState)
      TX_IDLE: begin
        next_st.txd      = 1'b1;
        next_st.shiftClk = (st.rxState != RX_SHIFT) || (st.m0Cnt >= M0_HALF);
        if (busWr && avsReq.address == OFS_HOLDING) begin
          if (mode == MODE_SHIFT) begin
            next_st.txState = TX_SHIFT;
            next_st.txShift = {3'h0, avsReq.writedata};
            next_st.txBits  = M0_BITS;
            next_st.m0Cnt   = 3'h0; // Full first bit period
          end else begin
            next_st.txState = TX_ASYNC;
            next_st.txShift = {1'b1, nineBit ? st.tb8 : 1'b1,
                               avsReq.writedata, 1'b0};
            next_st.txBits  = nineBit ? TX_BITS_9 : TX_BITS_8;
            next_st.txCnt   = 4'h0;
          end
        end
      end
      TX_ASYNC: begin
        next_st.txd = st.txShift[0];
        if (tick) begin
          next_st.txCnt = st.txCnt + 4'h1;
          if (st.txCnt == LAST_PHASE) begin
            next_st.txShift = {1'b1, st.txShift[10:1]};
            next_st.txBits  = st.txBits - 4'h1;
            if (st.txBits == 4'h2) begin
              next_st.ti = 1'b1;
            end
            if (st.txBits == 4'h1) begin
              next_st.txState = TX_IDLE;
            end
          end
        end
      end
      TX_SHIFT: begin
        next_st.txd      = st.txShift[0];
        next_st.shiftClk = (st.m0Cnt >= M0_HALF);
        if (st.m0Cnt == M0_LAST) begin
          next_st.txShift = {1'b0, st.txShift[10:1]};
          next_st.txBits  = st.txBits - 4'h1;
          if (st.txBits == 4'h1) begin
            next_st.ti      = 1'b1;
            next_st.txState = TX_IDLE;
          end
        end
      end
      default: next_st.txState = TX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.waitreq  <= 1'b1;
      st.rxS1     <= 1'b1;
      st.rxS2     <= 1'b1;
      st.rxLast   <= 1'b1;
      st.txd      <= 1'b1;
      st.shiftClk <= 1'b1;
      st.slave_address_register    <= RST_BYTE;
      st.slave_address_mask    <= RST_BYTE;
      st.baudDiv  <= RST_BAUD_DIV;
      st.rxState  <= RX_IDLE;
      st.txState  <= TX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign avsRsp.readdata    = st.readdata;
  assign avsRsp.waitrequest = st.waitreq;
  assign txd                = st.txd;
  assign shiftClk           = st.shiftClk;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic sconWr;
  assign sconWr = busWr && avsReq.address == OFS_SERIAL_CONTROL;
  sequence s_startSeen;
    st.rxState == RX_IDLE && st.ren && mode != MODE_SHIFT && tick && rxFall;
  endsequence
  sequence s_acceptFrame;
    rxFinal && rxAccept && !sconWr;
  endsequence
  property p_startAlign;
    s_startSeen |=> st.rxState == RX_START && st.rxCnt == 4'h0;
  endproperty
  a_startAlign: assert property (p_startAlign)
    else $error("start edge did not reset the bit counter");
  property p_falseStart;
    startBad |=> st.rxState == RX_IDLE;
  endproperty
  a_falseStart: assert property (p_falseStart)
    else $error("false start bit not rejected");
  property p_acceptLoad;
    s_acceptFrame |=> st.ri && st.rxBuf == $past(rxData)
                      && st.rb8 == $past(rxNinth);
  endproperty
  a_acceptLoad: assert property (p_acceptLoad)
    else $error("accepted frame not loaded");
  property p_busyDrop;
    rxFinal && st.ri && !busWr |=> $stable(st.rxBuf) && $stable(st.rb8);
  endproperty
  a_busyDrop: assert property (p_busyDrop)
    else $error("frame overwrote unread buffer");
  property p_filter9;
    rxFinal && nineBit && st.sm2 && !st.ri && !(rxNinth && addrMatch)
      && !sconWr |=> !st.ri;
  endproperty
  a_filter9: assert property (p_filter9)
    else $error("unmatched address set receive done");
  property p_feSticky;
    st.fe && !sconWr |=> st.fe;
  endproperty
  a_feSticky: assert property (p_feSticky)
    else $error("framing error cleared without software");
  property p_feSet;
    rxFinal && !vote |=> st.fe;
  endproperty
  a_feSet: assert property (p_feSet)
    else $error("bad stop bit missed");
  property p_bit7Read;
    avsReq.read && st.waitreq && avsReq.address == OFS_SERIAL_CONTROL
      |=> avsRsp.readdata[7] == ($past(st.framing_select) ? $past(st.fe)
                                                 : $past(st.sm0));
  endproperty
  a_bit7Read: assert property (p_bit7Read)
    else $error("control bit 7 read wrong");
  property p_ninthOut;
    st.txState == TX_IDLE && busWr && avsReq.address == OFS_HOLDING
      && nineBit |=> st.txShift[9] == $past(st.tb8);
  endproperty
  a_ninthOut: assert property (p_ninthOut)
    else $error("ninth bit not loaded into frame");
  property p_tiStop;
    st.txState == TX_ASYNC && tick && st.txCnt == LAST_PHASE
      && st.txBits == 4'h2 |=> st.ti ##1 st.txd;
  endproperty
  a_tiStop: assert property (p_tiStop)
    else $error("transmit done not set at stop bit");
endmodule // urx_uart

// ==== dv/urx_serial_node.sv ====
// Serial node model: sends frames on the receive line, captures transmit line
module urx_serial_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic core_clk,
  input  wire logic txd,
  input  wire logic shiftClk,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line idles high between frames
  initial rxd = 1'b1;

  // ----------------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------------
  // Low start, payload LSB first, stop is the last payload bit
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    rxd <= 1'b1;
  endtask

  // Short low pulse that must not pass the start vote
  task automatic glitch();
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (3) @(posedge core_clk);
    rxd <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge core_clk);
  endtask

  // Mode 0 input: next bit is placed while the shift clock is low
  task automatic shift_in(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      while (shiftClk !== 1'b0) @(posedge core_clk);
      rxd <= b[i];
      while (shiftClk !== 1'b1) @(posedge core_clk);
    end
    rxd <= 1'b1;
  endtask

  // ----------------------------------------------------------------------
  // Frame capture, sampled mid-bit
  // ----------------------------------------------------------------------
  task automatic recv(output logic [9:0] bits);
    while (txd !== 1'b0) @(posedge core_clk);
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      bits[i] = txd;
    end
  endtask
endmodule // urx_serial_node

// ==== dv/urx_uart_tb_top.sv ====
// Self-checking testbench for the serial port block
module urx_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import urx_pkg::*;

  logic          coreClk;
  logic          rstN;
  urx_avs_req_t  avsReq;
  urx_avs_rsp_t  avsRsp;
  logic          rxd;
  logic          txd;
  logic          shiftClk;
  int            mismatches;
  int            cmp_count;
  int            cycles;

  urx_uart dut (
    .core_clk (coreClk),
    .rst_n    (rstN),
    .avsReq   (avsReq),
    .avsRsp   (avsRsp),
    .rxd      (rxd),
    .txd      (txd),
    .shiftClk (shiftClk)
  );

  urx_serial_node #(.BIT_CLKS(16)) node (
    .core_clk (coreClk),
    .txd      (txd),
    .shiftClk (shiftClk),
    .rxd      (rxd)
  );

  initial begin
    coreClk = 1'b0;
    forever #12.5 coreClk = ~coreClk;
  end

  // ----------------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic wr, input logic [7:0] addr,
                     input logic [7:0] wdata, output logic [7:0] rdata);
    avsReq.read      <= ~wr;
    avsReq.write     <= wr;
    avsReq.address   <= addr;
    avsReq.writedata <= wdata;
    @(posedge coreClk);
    while (avsRsp.waitrequest !== 1'b0) @(posedge coreClk);
    rdata = avsRsp.readdata;
    avsReq.read  <= 1'b0;
    avsReq.write <= 1'b0;
    @(posedge coreClk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    bus(1'b1, addr, data, d);
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, addr, 8'h00, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_check(OFS_SERIAL_CONTROL, 8'h00);
    rd_check(OFS_SLAVE_ADDRESS, 8'h00);
    rd_check(OFS_SLAVE_MASK, 8'h00);
    wr(8'hA0, 8'hFF);
    rd_check(8'hA0, 8'h00);
    rd_check(OFS_SERIAL_CONTROL, 8'h00);
  endtask

  task automatic t_mode1_rx();
    wr(OFS_SERIAL_CONTROL, 8'h50);
    node.send({2'b01, 8'hA5}, 9);
    rd_check(OFS_SERIAL_CONTROL, 8'h55);
    rd_check(OFS_HOLDING, 8'hA5);
    // Frame arriving while done flag is set is lost
    node.send({2'b01, 8'h3C}, 9);
    rd_check(OFS_HOLDING, 8'hA5);
    wr(OFS_SERIAL_CONTROL, 8'h50);
    node.glitch();
    rd_check(OFS_SERIAL_CONTROL, 8'h50);
    node.send({2'b01, 8'h96}, 9);
    rd_check(OFS_HOLDING, 8'h96);
  endtask

  task automatic t_mode2_filter();
    logic [8:0] byt [4] = '{9'h1C2, 9'h0C0, 9'h101, 9'h1FF};
    logic       acc [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    wr(OFS_POWER_CONTROL, 8'h80);
    wr(OFS_SLAVE_ADDRESS, 8'hC0);
    wr(OFS_SLAVE_MASK, 8'hFD);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SERIAL_CONTROL, 8'hB0);
      node.send({1'b1, byt[i]}, 10);
      rd_check(OFS_SERIAL_CONTROL, acc[i] ? 8'hB5 : 8'hB0);
      if (acc[i]) begin
        rd_check(OFS_HOLDING, byt[i][7:0]);
      end
    end
  endtask

  task automatic t_mode3_tx();
    logic [9:0] bits;
    wr(OFS_SERIAL_CONTROL, 8'hC8);
    fork
      node.recv(bits);
      wr(OFS_HOLDING, 8'h3C);
    join
    check({6'h00, bits}, 16'h033C);
    rd_check(OFS_SERIAL_CONTROL, 8'hCA);
    // Stop bit must end before the next holding write, else it is ignored
    repeat (16) @(posedge coreClk);
  endtask

  task automatic t_mode0_tx();
    logic [7:0] b;
    wr(OFS_SERIAL_CONTROL, 8'h00);
    wr(OFS_HOLDING, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      while (shiftClk !== 1'b0) @(posedge coreClk);
      while (shiftClk !== 1'b1) @(posedge coreClk);
      b[i] = txd;
    end
    check({8'h00, b}, 16'h005A);
    repeat (12) @(posedge coreClk);
    rd_check(OFS_SERIAL_CONTROL, 8'h02);
  endtask

  task automatic t_mode0_rx();
    wr(OFS_SERIAL_CONTROL, 8'h10);
    node.shift_in(8'hC3);
    repeat (12) @(posedge coreClk);
    rd_check(OFS_SERIAL_CONTROL, 8'h11);
    rd_check(OFS_HOLDING, 8'hC3);
  endtask

  task automatic t_framing();
    wr(OFS_SERIAL_CONTROL, 8'h70);
    wr(OFS_POWER_CONTROL, 8'h40);
    node.send({2'b00, 8'h81}, 9);
    rd_check(OFS_SERIAL_CONTROL, 8'hF0);
    node.send({2'b01, 8'h44}, 9);
    rd_check(OFS_SERIAL_CONTROL, 8'hF5);
    rd_check(OFS_HOLDING, 8'h44);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstN       = 1'b0;
    avsReq     = '0;
    mismatches = 0;
    cmp_count  = 0;
    cycles     = 0;
    repeat (2) @(posedge coreClk);
    rstN <= 1'b1;
    @(posedge coreClk);
    t_reset();
    t_mode1_rx();
    t_mode2_filter();
    t_mode3_tx();
    t_mode0_tx();
    t_mode0_rx();
    t_framing();
    finish_test();
  end
endmodule // urx_uart_tb_top
